// *** rtl/core_decode_pkg.sv ***
// shared constants for the core address decoder
package core_decode_pkg;
   localparam int unsigned ADDR_W = 21;
   typedef logic [20:0] addr_t;

   // region bounds (inclusive), core byte addresses
   localparam addr_t BASE_LO_END    = 21'h00dfff;
   localparam addr_t BOOT_BASE_END  = 21'h000fff;
   localparam addr_t RAM_BIG_START  = 21'h00e800;
   localparam addr_t RAM_SML_START  = 21'h00f000;
   localparam addr_t RAM_END        = 21'h00f7ff;
   localparam addr_t FLCTL_START    = 21'h00f880;
   localparam addr_t FLCTL_END      = 21'h00f8ff;
   localparam addr_t SECREG_START   = 21'h00f900;
   localparam addr_t SECREG_END     = 21'h00f90a;
   localparam addr_t BIUREG_START   = 21'h00f980;
   localparam addr_t BIUREG_END     = 21'h00f98f;
   localparam addr_t DMAREG_START   = 21'h00fa00;
   localparam addr_t DMAREG_END     = 21'h00fa7f;
   localparam addr_t IOEXP_START    = 21'h00fb00;
   localparam addr_t IOEXP_END      = 21'h00fbff;
   localparam addr_t PERIPH_START   = 21'h00fc00;
   localparam addr_t PERIPH_END     = 21'h00ffff;
   localparam addr_t BASE_HI_START  = 21'h010000;
   localparam addr_t BASE_HI_END    = 21'h01ffff;
   localparam addr_t SLOW_START     = 21'h020000;
   localparam addr_t MID_END        = 21'h0fffff;
   localparam addr_t XMEM_START     = 21'h100000;
   localparam addr_t XMEM_END       = 21'h1fffff;
   localparam addr_t XMEM_ALIAS_MSK = 21'h0fffff;

   // device variants
   typedef enum logic [1:0]
   {
      VAR_SMALL_FLASH = 2'h0,
      VAR_LARGE_FLASH = 2'h1,
      VAR_BOOT_ROM    = 2'h2
   } variant_e;

   // operating environments
   typedef enum logic [1:0]
   {
      ENV_PRODUCTION  = 2'h0,
      ENV_ONBOARD_DBG = 2'h1,
      ENV_DEVELOPMENT = 2'h2,
      ENV_PROGRAMMING = 2'h3
   } env_e;

   // strap capture: settle count reached before the latch; the environment is held 3 cycles after reset release
   localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;

   // one-hot target select bit positions
   localparam int unsigned SEL_W       = 10;
   localparam int unsigned SEL_FLASH   = 0;
   localparam int unsigned SEL_EXTBASE = 1;
   localparam int unsigned SEL_RAM     = 2;
   localparam int unsigned SEL_FLCTL   = 3;
   localparam int unsigned SEL_SECREG  = 4;
   localparam int unsigned SEL_BIUREG  = 5;
   localparam int unsigned SEL_DMAREG  = 6;
   localparam int unsigned SEL_IOEXP   = 7;
   localparam int unsigned SEL_PERIPH  = 8;
   localparam int unsigned SEL_XMEM    = 9;
endpackage

// *** rtl/env_strap_latch.sv ***
// captures the operating environment from straps after reset release
`timescale 1ns/1ps
module env_strap_latch
   import core_decode_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [1:0] environment_straps,
   input  wire logic       tristate_strap,
   output env_e            env,
   output logic            env_valid
);
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   logic [1:0] cnt_ff;
   logic [1:0] nxt_cnt;
   env_e       env_ff;
   env_e       nxt_env;
   logic       valid_ff;
   logic       nxt_valid;
   logic [2:0] strap_s;

   // pin synchroniser
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_ff <= 3'h0;
         sync2_ff <= 3'h0;
      end
      else
      begin
         sync1_ff <= {tristate_strap, environment_straps};
         sync2_ff <= sync1_ff;
      end
   end

   assign strap_s = sync2_ff;

   // settle, then latch once and hold
   always_comb
   begin
      nxt_cnt   = cnt_ff;
      nxt_env   = env_ff;
      nxt_valid = valid_ff;
      if (!valid_ff)
      begin
         if (cnt_ff != STRAP_SETTLE_CYC)
            nxt_cnt = cnt_ff + 2'h1;
         else
         begin
            nxt_valid = 1'b1;
            case (strap_s[1:0])
               2'h0:    nxt_env = ENV_PRODUCTION;
               2'h2:    nxt_env = ENV_ONBOARD_DBG;
               2'h1:    nxt_env = ENV_DEVELOPMENT;
               default: nxt_env = ENV_PROGRAMMING;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_ff   <= 2'h0;
         env_ff   <= ENV_PRODUCTION;
         valid_ff <= 1'b0;
      end
      else
      begin
         cnt_ff   <= nxt_cnt;
         env_ff   <= nxt_env;
         valid_ff <= nxt_valid;
      end
   end

   assign env       = env_ff;
   assign env_valid = valid_ff;

   a_env_held: assert property (@(posedge clk) disable iff (!resetn)
      $past(valid_ff) |-> (valid_ff && $stable(env_ff)))
      else $error("environment changed after latch");
endmodule

// *** rtl/core_address_decoder.sv ***
// core address space decoder steering accesses to one target
`timescale 1ns/1ps
// Behaviour
// - one 2 Mbyte core space for all targets
// - base memory internal, or external in development
// - reserved addresses select nothing, undefined
// - flash variants: 0 to DFFF base memory
// - large flash: RAM E800 to F7FF
// - small flash, boot ROM: RAM F000-F7FF
// - F880 to F8FF flash control registers
// - F900 to F90A security registers
// - F980 to F98F bus interface unit registers
// - FA00 to FA7F DMA registers
// - FB00 to FBFF I/O expansion
// - FC00 to FFFF peripheral registers
// - large flash: 10000-1FFFF base memory continues
// - large flash: 20000-FFFFF external only in development
// - small flash: 10000-FFFFF reserved/external, or expansion on boot ROM
// - 100000-1FFFFF expansion memory on all variants
// - expansion memory only in large package
// - boot ROM: base memory only 0 to FFF
// - boot ROM: 1000-DFFF expansion memory
// - boot ROM expansion 1 Mbyte, low/high aliased
// - environment latched from straps after reset
module core_address_decoder
   import core_decode_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic [1:0]        environment_straps,
   input  wire logic              tristate_strap,
   input  wire logic [1:0]        variant,
   input  wire logic              large_package,
   input  wire logic              access_valid,
   input  wire logic [20:0]       core_addr,
   output logic [SEL_W-1:0]       target_sel,
   output logic [19:0]            xmem_addr,
   output logic                   access_unmapped,
   output env_e                   environment,
   output logic                   environment_valid
);
   env_e       env_w;
   logic       env_valid_w;
   logic       pkg_s1_ff;
   logic       pkg_s2_ff;
   logic [SEL_W-1:0] sel;
   logic       dev_env;
   logic       base_sel;
   variant_e   var_w;

   // region hits and qualifiers used only by the checks
   logic       live_acc;
   logic       hit_base_lo;
   logic       hit_boot_base;
   logic       hit_ram_big;
   logic       hit_ram_sml;
   logic       hit_secreg;
   logic       hit_biureg;
   logic       hit_dmareg;
   logic       hit_ioexp;
   logic       hit_periph;
   logic       hit_base_hi;
   logic       hit_slow;
   logic       hit_mid;
   logic       hit_xmem;
   logic       is_large;
   logic       is_small;
   logic       is_boot;
   logic       dev_seen;

   // inclusive range check
   function automatic logic in_rng(input addr_t a, input addr_t lo, input addr_t hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   env_strap_latch u_env
   (
      .clk                (clk),
      .resetn             (resetn),
      .environment_straps (environment_straps),
      .tristate_strap     (tristate_strap),
      .env                (env_w),
      .env_valid          (env_valid_w)
   );

   // package strap synchroniser
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pkg_s1_ff <= 1'b0;
         pkg_s2_ff <= 1'b0;
      end
      else
      begin
         pkg_s1_ff <= large_package;
         pkg_s2_ff <= pkg_s1_ff;
      end
   end

   assign var_w   = variant_e'(variant);
   assign dev_env = (env_w == ENV_DEVELOPMENT);

   // region decode
   always_comb
   begin
      sel      = '0;
      base_sel = 1'b0;
      if (access_valid && env_valid_w && env_w != ENV_PROGRAMMING)
      begin
         if (var_w == VAR_BOOT_ROM)
         begin
            if (in_rng(core_addr, '0, BOOT_BASE_END))
               base_sel = 1'b1;
            else if (in_rng(core_addr, BOOT_BASE_END + 21'h1, BASE_LO_END))
               sel[SEL_XMEM] = pkg_s2_ff;
            else if (in_rng(core_addr, BASE_HI_START, MID_END))
               sel[SEL_XMEM] = pkg_s2_ff;
         end
         else if (var_w == VAR_SMALL_FLASH || var_w == VAR_LARGE_FLASH)
         begin
            if (in_rng(core_addr, '0, BASE_LO_END))
               base_sel = 1'b1;
            else if (var_w == VAR_LARGE_FLASH && in_rng(core_addr, BASE_HI_START, BASE_HI_END))
               base_sel = 1'b1;
            else if (var_w == VAR_LARGE_FLASH && in_rng(core_addr, SLOW_START, MID_END))
               sel[SEL_EXTBASE] = dev_env;
            else if (var_w == VAR_SMALL_FLASH && in_rng(core_addr, BASE_HI_START, MID_END))
               sel[SEL_EXTBASE] = dev_env;
         end
         // system RAM by variant
         if (var_w == VAR_LARGE_FLASH && in_rng(core_addr, RAM_BIG_START, RAM_END))
            sel[SEL_RAM] = 1'b1;
         if (var_w != VAR_LARGE_FLASH && var_w != 2'h3
             && in_rng(core_addr, RAM_SML_START, RAM_END))
            sel[SEL_RAM] = 1'b1;
         // register blocks common to all variants
         sel[SEL_FLCTL]  = in_rng(core_addr, FLCTL_START, FLCTL_END);
         sel[SEL_SECREG] = in_rng(core_addr, SECREG_START, SECREG_END);
         sel[SEL_BIUREG] = in_rng(core_addr, BIUREG_START, BIUREG_END);
         sel[SEL_DMAREG] = in_rng(core_addr, DMAREG_START, DMAREG_END);
         sel[SEL_IOEXP]  = in_rng(core_addr, IOEXP_START, IOEXP_END);
         sel[SEL_PERIPH] = in_rng(core_addr, PERIPH_START, PERIPH_END);
         if (var_w != 2'h3 && in_rng(core_addr, XMEM_START, XMEM_END))
            sel[SEL_XMEM] = pkg_s2_ff;
         // base memory target by environment
         if (base_sel)
         begin
            sel[SEL_FLASH]   = !dev_env;
            sel[SEL_EXTBASE] = dev_env;
         end
      end
   end

   assign target_sel        = sel;
   assign access_unmapped   = access_valid && (sel == '0);
   assign xmem_addr         = core_addr[19:0] & XMEM_ALIAS_MSK[19:0];
   assign environment       = env_w;
   assign environment_valid = env_valid_w;

   // region hits that the checks below build on
   assign live_acc      = access_valid && environment_valid && (environment != ENV_PROGRAMMING);
   assign hit_base_lo   = (core_addr <= BASE_LO_END);
   assign hit_boot_base = (core_addr <= BOOT_BASE_END);
   assign hit_ram_big   = in_rng(core_addr, RAM_BIG_START, RAM_END);
   assign hit_ram_sml   = in_rng(core_addr, RAM_SML_START, RAM_END);
   assign hit_secreg    = in_rng(core_addr, SECREG_START, SECREG_END);
   assign hit_biureg    = in_rng(core_addr, BIUREG_START, BIUREG_END);
   assign hit_dmareg    = in_rng(core_addr, DMAREG_START, DMAREG_END);
   assign hit_ioexp     = in_rng(core_addr, IOEXP_START, IOEXP_END);
   assign hit_periph    = in_rng(core_addr, PERIPH_START, PERIPH_END);
   assign hit_base_hi   = in_rng(core_addr, BASE_HI_START, BASE_HI_END);
   assign hit_slow      = in_rng(core_addr, SLOW_START, MID_END);
   assign hit_mid       = in_rng(core_addr, BASE_HI_START, MID_END);
   assign hit_xmem      = (core_addr >= XMEM_START);
   assign is_large      = (variant == VAR_LARGE_FLASH);
   assign is_small      = (variant == VAR_SMALL_FLASH);
   assign is_boot       = (variant == VAR_BOOT_ROM);
   assign dev_seen      = (environment == ENV_DEVELOPMENT);

   // select shape
   a_one_hot_sel: assert property (@(posedge clk) disable iff (!resetn)
      $onehot0(target_sel))
      else $error("more than one target selected");

   a_idle_quiet: assert property (@(posedge clk) disable iff (!resetn)
      !access_valid |-> ((target_sel == '0) && !access_unmapped))
      else $error("select without access");

   a_early_quiet: assert property (@(posedge clk) disable iff (!resetn)
      !environment_valid |-> (target_sel == '0))
      else $error("select before environment held");

   a_prog_quiet: assert property (@(posedge clk) disable iff (!resetn)
      (environment == ENV_PROGRAMMING) |-> (target_sel == '0))
      else $error("select in programming environment");

   a_unmapped_flag: assert property (@(posedge clk) disable iff (!resetn)
      access_valid |-> (access_unmapped == (target_sel == '0)))
      else $error("unmapped flag wrong");

   // base memory
   a_base_low: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && (is_small || is_large) && hit_base_lo
      |-> (target_sel[SEL_FLASH] || target_sel[SEL_EXTBASE]))
      else $error("low base memory not selected");

   a_base_flash: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && (is_small || is_large) && hit_base_lo && !dev_seen |-> target_sel[SEL_FLASH])
      else $error("internal flash not selected");

   a_base_ext: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && (is_small || is_large) && hit_base_lo && dev_seen |-> target_sel[SEL_EXTBASE])
      else $error("external base not selected");

   a_flash_env: assert property (@(posedge clk) disable iff (!resetn)
      target_sel[SEL_FLASH] |-> (environment != ENV_DEVELOPMENT))
      else $error("internal flash selected in development");

   a_ext_dev_only: assert property (@(posedge clk) disable iff (!resetn)
      target_sel[SEL_EXTBASE] |-> dev_seen)
      else $error("external base outside development");

   a_base_hi_map: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && is_large && hit_base_hi
      |-> (target_sel[SEL_FLASH] || target_sel[SEL_EXTBASE]))
      else $error("upper base memory not selected");

   a_slow_dev: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && is_large && hit_slow |-> (target_sel[SEL_EXTBASE] == dev_seen))
      else $error("slow zone select wrong");

   a_slow_reserved: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && is_large && hit_slow && !dev_seen |-> (target_sel == '0))
      else $error("reserved slow zone selected");

   a_mid_small: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && is_small && hit_mid |-> (target_sel[SEL_EXTBASE] == dev_seen))
      else $error("small variant mid region wrong");

   a_boot_base: assert property (@(posedge clk) disable iff (!resetn)
      (variant == VAR_BOOT_ROM && (target_sel[SEL_FLASH] || target_sel[SEL_EXTBASE]))
      |-> (core_addr <= BOOT_BASE_END))
      else $error("boot ROM base memory too large");

   a_boot_base_map: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && is_boot && hit_boot_base
      |-> (target_sel[SEL_FLASH] || target_sel[SEL_EXTBASE]))
      else $error("boot base not selected");

   // system RAM
   a_ram_large: assert property (@(posedge clk) disable iff (!resetn)
      (target_sel[SEL_RAM] && core_addr < RAM_SML_START) |-> (variant == VAR_LARGE_FLASH))
      else $error("low RAM selected on small variant");

   a_ram_big_map: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && is_large && hit_ram_big |-> target_sel[SEL_RAM])
      else $error("large RAM not selected");

   a_ram_top_edge: assert property (@(posedge clk) disable iff (!resetn)
      (core_addr == RAM_END + 21'h1) |-> !target_sel[SEL_RAM])
      else $error("RAM window too large");

   a_ram_sml_map: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && (is_small || is_boot) && hit_ram_sml |-> target_sel[SEL_RAM])
      else $error("small RAM not selected");

   a_ram_sml_gap: assert property (@(posedge clk) disable iff (!resetn)
      (!is_large && core_addr < RAM_SML_START) |-> !target_sel[SEL_RAM])
      else $error("small RAM starts too low");

   // register windows
   a_flctl_map: assert property (@(posedge clk) disable iff (!resetn)
      (environment_valid && access_valid && environment != ENV_PROGRAMMING
       && core_addr >= FLCTL_START && core_addr <= FLCTL_END)
      |-> target_sel[SEL_FLCTL])
      else $error("flash control window not selected");

   a_flctl_edge: assert property (@(posedge clk) disable iff (!resetn)
      (core_addr == FLCTL_START - 21'h1) |-> !target_sel[SEL_FLCTL])
      else $error("flash control window too low");

   a_sec_map: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && hit_secreg |-> target_sel[SEL_SECREG])
      else $error("security window not selected");

   a_sec_edge: assert property (@(posedge clk) disable iff (!resetn)
      (core_addr == SECREG_END + 21'h1) |-> !target_sel[SEL_SECREG])
      else $error("security window too large");

   a_biu_map: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && hit_biureg |-> target_sel[SEL_BIUREG])
      else $error("bus unit window not selected");

   a_biu_edge: assert property (@(posedge clk) disable iff (!resetn)
      (core_addr == BIUREG_END + 21'h1) |-> !target_sel[SEL_BIUREG])
      else $error("bus unit window too large");

   a_dma_map: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && hit_dmareg |-> target_sel[SEL_DMAREG])
      else $error("DMA window not selected");

   a_dma_edge: assert property (@(posedge clk) disable iff (!resetn)
      (core_addr == DMAREG_END + 21'h1) |-> !target_sel[SEL_DMAREG])
      else $error("DMA window too large");

   a_ioexp_map: assert property (@(posedge clk) disable iff (!resetn)
      target_sel[SEL_IOEXP] |-> (core_addr[20:8] == IOEXP_START[20:8]))
      else $error("I/O expansion select outside window");

   a_ioexp_full: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && hit_ioexp |-> target_sel[SEL_IOEXP])
      else $error("I/O expansion not selected");

   a_periph_map: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && hit_periph |-> target_sel[SEL_PERIPH])
      else $error("peripheral window not selected");

   // expansion memory
   a_xmem_pkg: assert property (@(posedge clk) disable iff (!resetn)
      target_sel[SEL_XMEM] |-> pkg_s2_ff)
      else $error("expansion memory selected in small package");

   a_xmem_small_pkg: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && !pkg_s2_ff && hit_xmem |-> (target_sel == '0))
      else $error("top region selected in small package");

   a_xmem_top: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && variant != 2'h3 && hit_xmem |-> (target_sel[SEL_XMEM] == pkg_s2_ff))
      else $error("top expansion region wrong");

   a_mid_boot: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && is_boot && hit_mid |-> (target_sel[SEL_XMEM] == pkg_s2_ff))
      else $error("boot mid region wrong");

   a_boot_low_xmem: assert property (@(posedge clk) disable iff (!resetn)
      live_acc && is_boot && hit_base_lo && !hit_boot_base
      |-> (target_sel[SEL_XMEM] == pkg_s2_ff))
      else $error("boot low expansion wrong");

   a_xmem_alias: assert property (@(posedge clk) disable iff (!resetn)
      target_sel[SEL_XMEM] |-> (xmem_addr == core_addr[19:0]))
      else $error("expansion address not aliased");

   // environment
   a_env_steady: assert property (@(posedge clk) disable iff (!resetn)
      environment_valid |=> environment_valid && $stable(environment))
      else $error("environment not held");

   // main scenarios reached
   c_ram_hit: cover property (@(posedge clk) disable iff (!resetn) target_sel[SEL_RAM]);
   c_boot_low: cover property (@(posedge clk) disable iff (!resetn)
      is_boot && hit_base_lo && target_sel[SEL_XMEM]);
   c_xmem_hit: cover property (@(posedge clk) disable iff (!resetn) target_sel[SEL_XMEM]);
   c_ext_base: cover property (@(posedge clk) disable iff (!resetn) target_sel[SEL_EXTBASE]);
   c_unmapped: cover property (@(posedge clk) disable iff (!resetn) access_unmapped);
endmodule

// *** tb/core_access_model.sv ***
// processor core model issuing accesses to the decoder
`timescale 1ns/1ps
module core_access_model
   import core_decode_pkg::*;
(
   input  wire logic clk,
   output logic      access_valid,
   output addr_t     core_addr
);
   // bus idle at time zero
   initial
   begin
      access_valid = 1'b0;
      core_addr    = 21'h000000;
   end

   // one access launched just after the edge, held until the next
   task automatic issue(input addr_t a);
      @(posedge clk);
      #2;
      access_valid = 1'b1;
      core_addr    = a;
   endtask

   // released bus shows the inverse of the last address, never a stale match
   task automatic idle();
      @(posedge clk);
      #2;
      access_valid = 1'b0;
      core_addr    = ~core_addr;
   endtask
endmodule

// *** tb/tb_core_address_decoder.sv ***
// self-checking bench for the core address decoder
`timescale 1ns/1ps
module tb_core_address_decoder
   import core_decode_pkg::*;
;
   logic             clk;
   logic             resetn;
   logic [1:0]       environment_straps;
   logic [1:0]       variant;
   logic             large_package;
   logic             access_valid;
   addr_t            core_addr;
   logic [SEL_W-1:0] target_sel;
   logic [19:0]      xmem_addr;
   logic             access_unmapped;
   env_e             environment;
   logic             environment_valid;
   int               failures;
   int               cmp_count;

   // boundary addresses of every region
   localparam addr_t PTS [0:32] = '{21'h000000, 21'h00dfff, 21'h00e000, 21'h00e7ff,
      21'h00e800, 21'h00efff, 21'h00f000, 21'h00f7ff, 21'h00f800, 21'h00f87f, 21'h00f880,
      21'h00f8ff, 21'h00f900, 21'h00f90a, 21'h00f90b, 21'h00f980, 21'h00f98f, 21'h00f990,
      21'h00fa00, 21'h00fa7f, 21'h00fa80, 21'h00fb00, 21'h00fbff, 21'h00fc00, 21'h00ffff,
      21'h000fff, 21'h001000, 21'h010000, 21'h01ffff, 21'h020000, 21'h0fffff, 21'h100000,
      21'h1fffff};

   core_access_model core (.clk(clk), .access_valid(access_valid), .core_addr(core_addr));

   core_address_decoder uut
   (
      .clk                (clk),
      .resetn             (resetn),
      .environment_straps (environment_straps),
      .tristate_strap     (1'b0),
      .variant            (variant),
      .large_package      (large_package),
      .access_valid       (access_valid),
      .core_addr          (core_addr),
      .target_sel         (target_sel),
      .xmem_addr          (xmem_addr),
      .access_unmapped    (access_unmapped),
      .environment        (environment),
      .environment_valid  (environment_valid)
   );

   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic conclude();
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk_sel(input string nm, input logic [SEL_W-1:0] e, input logic [SEL_W-1:0] s);
      cmp_count++;
      if (s !== e)
      begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask

   task automatic chk_val(input string nm, input logic [19:0] e, input logic [19:0] s);
      cmp_count++;
      if (s !== e)
      begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask

   function automatic logic inr(addr_t a, addr_t lo, addr_t hi);
      return a >= lo && a <= hi;
   endfunction

   // expected one-hot select worked out from the map
   function automatic logic [SEL_W-1:0] exp_sel(logic [1:0] v, env_e e, logic p, addr_t a);
      logic [SEL_W-1:0] s;
      int unsigned      b;
      s = '0;
      b = (e == ENV_DEVELOPMENT) ? SEL_EXTBASE : SEL_FLASH;
      if (e == ENV_PROGRAMMING)
         return s;
      if (a <= BASE_LO_END)
         if (v != VAR_BOOT_ROM || a <= BOOT_BASE_END)
            s[b] = 1'b1;
         else
            s[SEL_XMEM] = p;
      s[SEL_RAM]    = inr(a, v == VAR_LARGE_FLASH ? RAM_BIG_START : RAM_SML_START, RAM_END);
      s[SEL_FLCTL]  = inr(a, FLCTL_START, FLCTL_END);
      s[SEL_SECREG] = inr(a, SECREG_START, SECREG_END);
      s[SEL_BIUREG] = inr(a, BIUREG_START, BIUREG_END);
      s[SEL_DMAREG] = inr(a, DMAREG_START, DMAREG_END);
      s[SEL_IOEXP]  = inr(a, IOEXP_START, IOEXP_END);
      s[SEL_PERIPH] = inr(a, PERIPH_START, PERIPH_END);
      if (inr(a, BASE_HI_START, MID_END))
         if (v == VAR_BOOT_ROM)
            s[SEL_XMEM] = p;
         else if (v == VAR_LARGE_FLASH && a <= BASE_HI_END)
            s[b] = 1'b1;
         else
            s[SEL_EXTBASE] = (e == ENV_DEVELOPMENT);
      if (a >= XMEM_START)
         s[SEL_XMEM] = p;
      return s;
   endfunction

   // reset with given straps; nothing decodes until the environment is held
   task automatic do_reset(input logic [1:0] st, input logic p, input env_e e);
      @(posedge clk);
      #2 resetn = 1'b0;
      environment_straps = st;
      large_package = p;
      variant = 2'h0;
      core.issue(21'h00f000);
      #1 chk_sel("sel in reset", '0, target_sel);
      chk_val("unmapped in reset", 20'h1, {19'h0, access_unmapped});
      repeat (12) @(posedge clk);
      chk_val("env in reset", 20'h0, {18'h0, environment});
      #2 resetn = 1'b1;
      repeat (2) @(posedge clk);
      #2 chk_val("env_valid early", 20'h0, {19'h0, environment_valid});
      @(posedge clk);
      #2 chk_val("env_valid", 20'h1, {19'h0, environment_valid});
      chk_val("environment", {18'h0, e}, {18'h0, environment});
   endtask

   // every variant against every boundary address
   task automatic sweep(input env_e e, input logic p);
      logic [SEL_W-1:0] x;
      for (int v = 0; v < 3; v++)
         for (int i = 0; i < 33; i++)
         begin
            core.issue(PTS[i]);
            variant = v[1:0];
            x = exp_sel(v[1:0], e, p, PTS[i]);
            #1 chk_sel($sformatf("sel v%0d a%h", v, PTS[i]), x, target_sel);
            chk_val("unmapped", {19'h0, x == '0}, {19'h0, access_unmapped});
         end
      core.idle();
   endtask

   task automatic t_production();
      do_reset(2'b00, 1'b1, ENV_PRODUCTION);
      sweep(ENV_PRODUCTION, 1'b1);
   endtask

   task automatic t_debug();
      do_reset(2'b10, 1'b1, ENV_ONBOARD_DBG);
      sweep(ENV_ONBOARD_DBG, 1'b1);
   endtask

   task automatic t_development();
      do_reset(2'b01, 1'b1, ENV_DEVELOPMENT);
      sweep(ENV_DEVELOPMENT, 1'b1);
   endtask

   task automatic t_programming();
      do_reset(2'b11, 1'b1, ENV_PROGRAMMING);
      sweep(ENV_PROGRAMMING, 1'b1);
   endtask

   task automatic t_small_package();
      do_reset(2'b00, 1'b0, ENV_PRODUCTION);
      sweep(ENV_PRODUCTION, 1'b0);
   endtask

   // low and high expansion windows reach the same locations
   task automatic t_alias();
      do_reset(2'b00, 1'b1, ENV_PRODUCTION);
      variant = VAR_BOOT_ROM;
      core.issue(21'h001234);
      #1 chk_val("xmem low", 20'h01234, xmem_addr);
      core.issue(21'h101234);
      #1 chk_val("xmem high", 20'h01234, xmem_addr);
      core.idle();
      #1 chk_val("idle unmapped", 20'h0, {19'h0, access_unmapped});
   endtask

   // main sequence
   initial
   begin
      failures = 0;
      cmp_count = 0;
      resetn = 1'b0;
      environment_straps = 2'b00;
      variant = 2'h0;
      large_package = 1'b1;
      t_production();
      t_debug();
      t_development();
      t_programming();
      t_small_package();
      t_alias();
      conclude();
   end

   // watchdog
   initial
   begin
      #(25 * 6000);
      failures++;
      conclude();
   end
endmodule
